// ===== inc/cos_pkg.sv
/*
 * Shared constants for the capability overlay set handler: register map,
 * command codes, overlay layout, capability reset values and result codes.
 * Assumes a 32-bit APB slave at pclk with registers on aligned words.
 */
`default_nettype none

package cos_pkg;
	// ************************************************************
	// Command decode
	// ************************************************************
	localparam logic [7:0]  CMD_CODE       = 8'hB1;   // Configuration command
	localparam logic [7:0]  FEAT_SET       = 8'h03;   // Overlay-set sub-feature
	localparam logic [7:0]  OVL_REVISION_LO = 8'h01;  // Revision word low byte
	localparam logic [7:0]  OVL_REVISION_HI = 8'h00;  // Revision word high byte
	localparam logic [7:0]  OVL_SIGNATURE  = 8'hA5;   // Integrity word low byte
	localparam int          DRV_BIT        = 4;       // Drive select in device/head

	// ************************************************************
	// Overlay layout (byte offsets inside the 512-byte sector)
	// ************************************************************
	localparam logic [8:0]  OVL_BYTES      = 9'h1FF;  // Last byte index
	localparam logic [8:0]  B_MW_LO        = 9'h002;  // Word 1 low byte
	localparam logic [8:0]  B_MW_HI        = 9'h003;  // Word 1 high byte
	localparam logic [8:0]  B_UD_LO        = 9'h004;  // Word 2 low byte
	localparam logic [8:0]  B_UD_HI        = 9'h005;  // Word 2 high byte
	localparam logic [8:0]  B_LBA_FIRST    = 9'h006;  // Word 3 low byte
	localparam logic [8:0]  B_LBA_LAST     = 9'h00D;  // Word 6 high byte
	localparam logic [8:0]  B_SIG          = 9'h1FE;  // Word 255 low byte
	localparam logic [7:0]  WORD_MW        = 8'h01;   // Word offsets for reports
	localparam logic [7:0]  WORD_UD        = 8'h02;

	// ************************************************************
	// Capability reset values
	// ************************************************************
	localparam logic [2:0]  MW_FULL        = 3'h7;
	localparam logic [5:0]  UD_FULL        = 6'h3F;
	localparam logic [63:0] LBA_NATIVE     = 64'h0000_0000_0FFF_FFFF;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0]  A_TASK         = 8'h00;   // W: features,devhead,command
	localparam logic [7:0]  A_DATA         = 8'h04;   // W: data word (push)
	localparam logic [7:0]  A_STATUS       = 8'h08;   // R: busy, abort, done, err regs
	localparam logic [7:0]  A_CAPS         = 8'h0C;   // R: reported words 1 and 2
	localparam logic [7:0]  A_MAXLO        = 8'h10;   // R: max LBA low
	localparam logic [7:0]  A_MAXHI        = 8'h14;   // R: max LBA high
	localparam logic [7:0]  A_CTRL         = 8'h18;   // RW: own drive, selections, hpa
	localparam logic [7:0]  A_CMASK        = 8'h1C;   // R: error bit-location mask

	// Control register fields
	localparam int          C_OWN          = 0;       // This drive's select value
	localparam int          C_HPA          = 1;       // Protected area exists
	localparam int          C_FRZ          = 2;       // Freeze lock active
	localparam int          C_MWSEL_LSB    = 8;       // One-hot mw selection, 3 bits
	localparam int          C_UDSEL_LSB    = 16;      // One-hot ud selection, 6 bits
endpackage

`default_nettype wire

// ===== hw/cos_sector_buf.sv
/*
 * Small sector memory holding one received overlay, byte wide.
 * Assumes one writer and one reader on pclk; read data is registered.
 */
`timescale 1ns/100ps
`default_nettype none

module cos_sector_buf #(
	parameter int DEPTH = 512,
	parameter int AW    = 9
) (
	input  wire logic          pclk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data
);
	// ************************************************************
	// Storage
	// ************************************************************
	logic [7:0] mem [DEPTH];   // No reset: content is always written first

	// Write port
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge pclk) begin
		rd_data <= mem[rd_addr];
	end
endmodule

`default_nettype wire

// ===== hw/cos_checker.sv
/*
 * Reduction checker: given the current capabilities and selections
 * and the proposed overlay words, says which cleared bits are
 * forbidden. Purely combinational; assumes the caller registers results.
 */
`timescale 1ns/100ps
`default_nettype none

module cos_checker (
	input  wire logic [2:0] mw_cur,
	input  wire logic [2:0] mw_sel,
	input  wire logic [5:0] ud_cur,
	input  wire logic [5:0] ud_sel,
	input  wire logic [2:0] mw_new,
	input  wire logic [5:0] ud_new,
	output logic      [2:0] mw_bad,
	output logic      [5:0] ud_bad
);
	// ************************************************************
	// Forbidden-clear detection
	// ************************************************************
	// A bit is cleared when it is set now and zero in the proposal.
	// Higher "stays supported" is judged on the proposed result.
	always_comb begin
		mw_bad = 3'h0;
		ud_bad = 6'h0;
		// Mode 2 cannot go while selected
		if (mw_cur[2] && !mw_new[2] && mw_sel[2]) begin
			mw_bad[2] = 1'b1;
		end
		// Mode 1 needs mode 2 gone and neither selected
		if (mw_cur[1] && !mw_new[1] && (mw_new[2] || mw_sel[2] || mw_sel[1])) begin
			mw_bad[1] = 1'b1;
		end
		// Mode 0 is mandatory
		if (mw_cur[0] && !mw_new[0]) begin
			mw_bad[0] = 1'b1;
		end
		// Top synchronous mode only blocked by its own selection
		if (ud_cur[5] && !ud_new[5] && ud_sel[5]) begin
			ud_bad[5] = 1'b1;
		end
		// Lower modes: no higher mode left, none at or above selected
		for (int n = 0; n < 5; n++) begin
			if (ud_cur[n] && !ud_new[n] &&
			    (((ud_new & ud_cur) >> (n + 1)) != 6'h0 || (ud_sel >> n) != 6'h0)) begin
				ud_bad[n] = 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// ===== hw/cos_set_handler.sv
/*
 * Top of the capability overlay set handler. Software posts the task file
 * and then pushes the 512-byte overlay as 256 16-bit data words over APB.
 * Assumes the host posts a command, then exactly 256 data words.
 */
// Design decisions made here: the register addresses and the APB register port.
// Operation
// - Command B1h with feature 03h selects overlay set
// - Only the addressed drive executes
// - Overlay changes only covered capability bits
// - Cleared bit removes the capability from reports
// - Bits set beyond full capability are ignored
// - Word 1 bits 15-3 reserved zero
// - Multiword mode 2 kept while selected
// - Multiword mode 1 kept if 2 supported/selected
// - Multiword mode 0 never cleared
// - Synchronous mode 5 kept while selected
// - Synchronous modes 4-1 kept if higher remain
// - Synchronous mode 0 kept if higher remain
// - Words 3-6 become the highest address
// - Reported maximum address follows the new value
// - Abort on freeze lock or forbidden clear
// - Signature A5h and zero byte checksum
// - Abort reports offending word offset, else 00h
`timescale 1ns/100ps
`default_nettype none

module cos_set_handler (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	// ************************************************************
	// Types and state
	// ************************************************************
	typedef enum logic [2:0] {S_IDLE, S_RECV, S_SCAN, S_CHECK, S_FINISH} cos_state_t;

	cos_state_t  state_r;            // Command sequencer
	logic [8:0]  wptr_r;             // Byte write pointer
	logic [8:0]  rptr_r;             // Byte scan pointer
	logic        rvalid_r;           // Read data valid, one cycle behind
	logic [8:0]  raddr_d_r;          // Address of the byte now on rd_data
	logic [7:0]  sum_r;              // Running byte sum
	logic        hdr_ok_r;           // Revision word bytes seen correct
	logic        sig_ok_r;           // Signature byte seen correct
	logic [15:0] mw_w_r;             // Proposed word 1
	logic [15:0] ud_w_r;             // Proposed word 2
	logic [63:0] lba_w_r;            // Proposed words 3-6
	logic [2:0]  mw_cap_r;           // Reported multiword modes
	logic [5:0]  ud_cap_r;           // Reported synchronous modes
	logic [63:0] max_lba_r;          // Highest accepted address
	logic        busy_r;             // Command in progress
	logic        done_r;             // Last command completed
	logic        abort_r;            // Last command aborted
	logic [7:0]  err_word_r;         // Offending word offset
	logic [15:0] err_mask_r;         // Offending bit positions
	logic [31:0] ctrl_r;             // Control register
	logic [31:0] prdata_r;           // Read data register
	logic        pready_r;           // Access answer
	logic        pslverr_r;          // Unmapped-address error

	logic [7:0]  rd_byte;            // Byte out of the sector memory
	logic        wr_en;              // Memory write strobe
	logic [8:0]  wr_addr;
	logic [7:0]  wr_data;
	logic        hi_phase_r;         // Second byte of a pushed word pending
	logic [7:0]  hi_byte_r;          // High byte held for the second write
	logic [2:0]  mw_new;             // Proposal limited to current capability
	logic [5:0]  ud_new;
	logic [2:0]  mw_bad;
	logic [5:0]  ud_bad;

	// ************************************************************
	// APB decode
	// ************************************************************
	wire logic acc    = psel && penable && !pready_r;   // Answer one cycle after access
	wire logic wr_acc = acc && pwrite;
	wire logic mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);

	// Command decode: right code, right sub-feature, this drive, idle
	wire logic cmd_hit = wr_acc && (paddr == cos_pkg::A_TASK) && !busy_r &&
	                     (pwdata[23:16] == cos_pkg::CMD_CODE) &&
	                     (pwdata[7:0] == cos_pkg::FEAT_SET) &&
	                     (pwdata[8 + cos_pkg::DRV_BIT] == ctrl_r[cos_pkg::C_OWN]);
	wire logic data_push = wr_acc && (paddr == cos_pkg::A_DATA) &&
	                       (state_r == S_RECV) && !hi_phase_r;

	// Access answer, one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= acc;
			pslverr_r <= acc && !mapped;
		end
	end

	// Read mux, registered at the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (acc && !pwrite) begin
			case (paddr)
				cos_pkg::A_STATUS: prdata_r <= {err_mask_r[7:0], err_word_r, 13'h0000,
				                                abort_r, done_r, busy_r};
				cos_pkg::A_CAPS:   prdata_r <= {10'h000, ud_cap_r, 13'h0000, mw_cap_r};
				cos_pkg::A_MAXLO:  prdata_r <= max_lba_r[31:0];
				cos_pkg::A_MAXHI:  prdata_r <= max_lba_r[63:32];
				cos_pkg::A_CTRL:   prdata_r <= ctrl_r;
				cos_pkg::A_CMASK:  prdata_r <= {16'h0000, err_mask_r};
				default:           prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Control register, software-owned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 32'h0000_0000;
		end else if (wr_acc && (paddr == cos_pkg::A_CTRL)) begin
			ctrl_r <= pwdata & 32'h003F_0707;
		end
	end

	// ************************************************************
	// Overlay reception: one word becomes two bytes, low first
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_phase_r <= 1'b0;
			hi_byte_r  <= 8'h00;
			wptr_r     <= 9'h000;
		end else if (cmd_hit) begin
			hi_phase_r <= 1'b0;
			wptr_r     <= 9'h000;
		end else if (data_push) begin
			hi_phase_r <= 1'b1;
			hi_byte_r  <= pwdata[15:8];
			wptr_r     <= wptr_r + 9'h001;
		end else if (hi_phase_r) begin
			hi_phase_r <= 1'b0;
			wptr_r     <= wptr_r + 9'h001;
		end
	end

	assign wr_en   = data_push || hi_phase_r;
	assign wr_addr = wptr_r;
	assign wr_data = hi_phase_r ? hi_byte_r : pwdata[7:0];

	cos_sector_buf #(.DEPTH(512), .AW(9)) u_buf (
		.pclk    (pclk),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_addr (rptr_r),
		.rd_data (rd_byte)
	);

	// ************************************************************
	// Sequencer
	// ************************************************************
	// Nothing is applied until the whole sector has been scanned.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r  <= S_IDLE;
			rptr_r   <= 9'h000;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= (state_r == S_SCAN);
			case (state_r)
				S_IDLE: begin
					if (cmd_hit) begin
						state_r <= ctrl_r[cos_pkg::C_FRZ] ? S_FINISH : S_RECV;
					end
				end
				S_RECV: begin
					if (hi_phase_r && wptr_r == cos_pkg::OVL_BYTES) begin
						state_r <= S_SCAN;
						rptr_r  <= 9'h000;
					end
				end
				S_SCAN: begin
					if (rptr_r == cos_pkg::OVL_BYTES) begin
						state_r <= S_CHECK;
					end else begin
						rptr_r <= rptr_r + 9'h001;
					end
				end
				S_CHECK: begin
					if (!rvalid_r) begin
						state_r <= S_FINISH;
					end
				end
				S_FINISH: state_r <= S_IDLE;
				default:  state_r <= S_IDLE;
			endcase
		end
	end

	// Byte scan: sum, header and field capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raddr_d_r <= 9'h000;
			sum_r     <= 8'h00;
			hdr_ok_r  <= 1'b0;
			sig_ok_r  <= 1'b0;
			mw_w_r    <= 16'h0000;
			ud_w_r    <= 16'h0000;
			lba_w_r   <= 64'h0000_0000_0000_0000;
		end else if (cmd_hit) begin
			sum_r    <= 8'h00;
			hdr_ok_r <= 1'b1;
			sig_ok_r <= 1'b0;
		end else begin
			raddr_d_r <= rptr_r;
			if (rvalid_r) begin
				sum_r <= sum_r + rd_byte;
				case (raddr_d_r)
					9'h000:  hdr_ok_r <= hdr_ok_r && (rd_byte == cos_pkg::OVL_REVISION_LO);
					9'h001:  hdr_ok_r <= hdr_ok_r && (rd_byte == cos_pkg::OVL_REVISION_HI);
					cos_pkg::B_MW_LO: mw_w_r[7:0]  <= rd_byte;
					cos_pkg::B_MW_HI: mw_w_r[15:8] <= rd_byte;
					cos_pkg::B_UD_LO: ud_w_r[7:0]  <= rd_byte;
					cos_pkg::B_UD_HI: ud_w_r[15:8] <= rd_byte;
					cos_pkg::B_SIG:   sig_ok_r <= (rd_byte == cos_pkg::OVL_SIGNATURE);
					default: begin
						if (raddr_d_r >= cos_pkg::B_LBA_FIRST && raddr_d_r <= cos_pkg::B_LBA_LAST) begin
							lba_w_r <= {rd_byte, lba_w_r[63:8]};
						end
					end
				endcase
			end
		end
	end

	// ************************************************************
	// Reduction checks
	// ************************************************************
	// Set bits beyond the current capability are dropped here.
	assign mw_new = mw_w_r[2:0] & mw_cap_r;
	assign ud_new = ud_w_r[5:0] & ud_cap_r;

	cos_checker u_chk (
		.mw_cur (mw_cap_r),
		.mw_sel (ctrl_r[cos_pkg::C_MWSEL_LSB +: 3]),
		.ud_cur (ud_cap_r),
		.ud_sel (ctrl_r[cos_pkg::C_UDSEL_LSB +: 6]),
		.mw_new (mw_new),
		.ud_new (ud_new),
		.mw_bad (mw_bad),
		.ud_bad (ud_bad)
	);

	// Format errors also abort; reserved bits of word 1 must be zero.
	wire logic fmt_bad = !hdr_ok_r || !sig_ok_r || (sum_r != 8'h00) ||
	                     (mw_w_r[15:3] != 13'h0000);
	wire logic lba_change = (lba_w_r != max_lba_r);
	wire logic hpa_block  = ctrl_r[cos_pkg::C_HPA] && lba_change;

	// ************************************************************
	// Completion and apply
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mw_cap_r   <= cos_pkg::MW_FULL;
			ud_cap_r   <= cos_pkg::UD_FULL;
			max_lba_r  <= cos_pkg::LBA_NATIVE;
			busy_r     <= 1'b0;
			done_r     <= 1'b0;
			abort_r    <= 1'b0;
			err_word_r <= 8'h00;
			err_mask_r <= 16'h0000;
		end else if (cmd_hit) begin
			busy_r     <= 1'b1;
			done_r     <= 1'b0;
			abort_r    <= 1'b0;
			err_word_r <= 8'h00;
			err_mask_r <= 16'h0000;
		end else if (state_r == S_FINISH) begin
			busy_r <= 1'b0;
			done_r <= 1'b1;
			if (ctrl_r[cos_pkg::C_FRZ] || fmt_bad || hpa_block) begin
				abort_r <= 1'b1;
			end else if (mw_bad != 3'h0) begin
				abort_r    <= 1'b1;
				err_word_r <= cos_pkg::WORD_MW;
				err_mask_r <= {13'h0000, mw_bad};
			end else if (ud_bad != 6'h0) begin
				abort_r    <= 1'b1;
				err_word_r <= cos_pkg::WORD_UD;
				err_mask_r <= {10'h000, ud_bad};
			end else begin
				mw_cap_r  <= mw_new;
				ud_cap_r  <= ud_new;
				max_lba_r <= lba_w_r;
			end
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_finish_ok;
		(state_r == S_FINISH) && !ctrl_r[cos_pkg::C_FRZ] && !fmt_bad && !hpa_block &&
		(mw_bad == 3'h0) && (ud_bad == 6'h0);
	endsequence

	a_mw0_kept: assert property (@(posedge pclk) disable iff (!presetn)
		mw_cap_r[0]) else $error("multiword mode 0 lost");
	a_freeze_abort: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == S_FINISH) && ctrl_r[cos_pkg::C_FRZ] |=> abort_r && done_r)
		else $error("freeze lock did not abort");
	a_apply_lba: assert property (@(posedge pclk) disable iff (!presetn)
		s_finish_ok |=> (max_lba_r == $past(lba_w_r)) && !abort_r)
		else $error("address not applied");
	a_hpa_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == S_FINISH) && hpa_block |=> $stable(max_lba_r) && abort_r)
		else $error("protected area not honoured");
	a_caps_only_drop: assert property (@(posedge pclk) disable iff (!presetn)
		((mw_cap_r & ~$past(mw_cap_r)) == 3'h0) && ((ud_cap_r & ~$past(ud_cap_r)) == 6'h0))
		else $error("capability bit grew");
	a_sel_mode_kept: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r[cos_pkg::C_MWSEL_LSB + 2] && mw_cap_r[2] && $stable(ctrl_r) |=> mw_cap_r[2])
		else $error("selected multiword mode removed");
	a_ud5_kept: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r[cos_pkg::C_UDSEL_LSB + 5] && ud_cap_r[5] && $stable(ctrl_r) |=> ud_cap_r[5])
		else $error("selected synchronous mode removed");
	a_err_word: assert property (@(posedge pclk) disable iff (!presetn)
		abort_r && (err_mask_r == 16'h0000) |-> (err_word_r == 8'h00))
		else $error("word offset without offending bits");
	a_cmd_busy: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_hit |=> busy_r ##0 (state_r != S_IDLE))
		else $error("command not started");
	a_no_early: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == S_RECV) |=> $stable(max_lba_r) && $stable(mw_cap_r))
		else $error("change before validation");
	a_sig_check: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == S_FINISH) && !sig_ok_r |=> abort_r)
		else $error("bad signature accepted");
endmodule

`default_nettype wire

// ===== test/cos_host_model.sv
/*
 * Host adapter model: an APB master that posts task-file writes and
 * pushes whole 512-byte overlays as 256 data words.
 * Assumes one pclk domain and a slave that answers with pready.
 */
`timescale 1ns/100ps
`default_nettype none

module cos_host_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// ************************************************************
	// Bus cycles
	// ************************************************************
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// One transfer; request held until pready is seen high at an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// ************************************************************
	// Overlay transfer
	// ************************************************************
	// Whole sector in one go; bad flips the checksum by one
	task automatic send(input logic [15:0] mw, input logic [15:0] ud,
		input logic [63:0] lba, input logic bad);
		logic [15:0] w [0:255];
		logic [7:0]  s;
		logic [31:0] q;
		logic        e;
		for (int i = 0; i < 256; i++) w[i] = 16'h0000;
		w[0] = 16'h0001;
		w[1] = mw;
		w[2] = ud;
		for (int i = 0; i < 4; i++) w[3 + i] = lba[16 * i +: 16];
		s = 8'h00;
		for (int i = 0; i < 255; i++) s = s + w[i][7:0] + w[i][15:8];
		s = s + cos_pkg::OVL_SIGNATURE;
		w[255] = {8'h00 - s + {7'h00, bad}, cos_pkg::OVL_SIGNATURE};
		for (int i = 0; i < 256; i++) xfer(1'b1, cos_pkg::A_DATA, {16'h0000, w[i]}, q, e);
	endtask
endmodule

`default_nettype wire

// ===== test/cos_set_handler_test.sv
/*
 * Self-checking bench for the overlay set handler: each task drives
 * one scenario through the host model and judges the registers.
 * Assumes the design answers every APB transfer.
 */
`timescale 1ns/100ps
`default_nettype none

module cos_set_handler_test;
	logic        pclk = 1'b0;
	logic        presetn;
	logic        psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, st;
	int          errors = 0;
	int          n_checks = 0;

	// ************************************************************
	// Clock, design and host
	// ************************************************************
	always #5 pclk = ~pclk;

	cos_set_handler u_cos_set_handler (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	cos_host_model u_cos_host_model (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		u_cos_host_model.xfer(1'b0, a, 32'h0000_0000, d, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_cos_host_model.xfer(1'b1, a, d, q, e);
	endtask
	// Posts one command, optional overlay, then waits for not busy
	task automatic cmd(input logic [31:0] ctrl, input logic drv, input logic [7:0] feat,
		input logic [2:0] mw, input logic [5:0] ud, input logic [63:0] lba,
		input logic bad, input logic dat);
		wr(cos_pkg::A_CTRL, ctrl);
		wr(cos_pkg::A_TASK, {8'h00, cos_pkg::CMD_CODE, 3'h0, drv, 4'h0, feat});
		if (dat) u_cos_host_model.send({13'h0, mw}, {10'h0, ud}, lba, bad);
		do rd(cos_pkg::A_STATUS, st); while (st[0] !== 1'b0);
		st = st & 32'h00FF_0005; // Keep offending word, abort and busy
	endtask
	// Status, reported capabilities and low maximum address
	task automatic res(input logic [31:0] es, input logic [31:0] ec, input logic [31:0] el);
		chk(st, es);
		rd(cos_pkg::A_CAPS, q);
		chk(q, ec);
		rd(cos_pkg::A_MAXLO, q);
		chk(q, el);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic s_reset;
		rd(cos_pkg::A_CAPS, q);
		chk(q, 32'h003F_0007);
		rd(cos_pkg::A_MAXLO, q);
		chk(q, 32'h0FFF_FFFF);
		rd(cos_pkg::A_MAXHI, q);
		chk(q, 32'h0000_0000);
		wr(cos_pkg::A_CTRL, 32'hFFFF_FFFF);
		rd(cos_pkg::A_CTRL, q);
		chk(q, 32'h003F_0707);
		wr(cos_pkg::A_CTRL, 32'h0000_0000);
		rd(8'h20, q);
		chk({31'h0, e}, 32'h0000_0001);
	endtask
	// Blocked clears of selected modes, a legal reduction, then re-setting bits that are gone
	task automatic s_reduce;
		cmd(32'h0000_0400, 0, 8'h03, 3'h3, 6'h3F, 64'h0ABC_1234, 0, 1);
		res(32'h0001_0004, 32'h003F_0007, 32'h0FFF_FFFF);
		rd(cos_pkg::A_CMASK, q);
		chk(q, 32'h0000_0004);
		cmd(32'h0020_0000, 0, 8'h03, 3'h7, 6'h1F, 64'h0ABC_1234, 0, 1);
		res(32'h0002_0004, 32'h003F_0007, 32'h0FFF_FFFF);
		rd(cos_pkg::A_CMASK, q);
		chk(q, 32'h0000_0020);
		cmd(0, 0, 8'h03, 3'h3, 6'h07, 64'h0ABC_1234, 0, 1);
		res(0, 32'h0007_0003, 32'h0ABC_1234);
		rd(cos_pkg::A_MAXHI, q);
		chk(q, 32'h0000_0000);
		cmd(0, 0, 8'h03, 3'h7, 6'h3F, 64'h0ABC_1234, 0, 1);
		res(0, 32'h0007_0003, 32'h0ABC_1234);
	endtask
	// Clears against selections and remaining higher modes
	task automatic s_modes;
		cmd(32'h0002_0000, 0, 8'h03, 3'h3, 6'h03, 64'h0ABC_1234, 0, 1);
		res(0, 32'h0003_0003, 32'h0ABC_1234);
		cmd(32'h0002_0000, 0, 8'h03, 3'h3, 6'h01, 64'h0ABC_1234, 0, 1);
		res(32'h0002_0004, 32'h0003_0003, 32'h0ABC_1234);
		cmd(0, 0, 8'h03, 3'h3, 6'h02, 64'h0ABC_1234, 0, 1);
		res(32'h0002_0004, 32'h0003_0003, 32'h0ABC_1234);
		cmd(32'h0000_0200, 0, 8'h03, 3'h1, 6'h03, 64'h0ABC_1234, 0, 1);
		res(32'h0001_0004, 32'h0003_0003, 32'h0ABC_1234);
		cmd(0, 0, 8'h03, 3'h2, 6'h03, 64'h0ABC_1234, 0, 1);
		res(32'h0001_0004, 32'h0003_0003, 32'h0ABC_1234);
	endtask
	// Bad checksum must leave the address untouched
	task automatic s_sum;
		cmd(0, 0, 8'h03, 3'h3, 6'h03, 64'h0000_0777, 1, 1);
		res(32'h0000_0004, 32'h0003_0003, 32'h0ABC_1234);
	endtask
	// Other drive and wrong feature are ignored; own drive executes
	task automatic s_drive;
		cmd(0, 1, 8'h03, 3'h3, 6'h03, 64'h0000_0055, 0, 1);
		rd(cos_pkg::A_MAXLO, q);
		chk(q, 32'h0ABC_1234);
		cmd(0, 0, 8'h02, 3'h3, 6'h03, 64'h0000_0055, 0, 1);
		rd(cos_pkg::A_MAXLO, q);
		chk(q, 32'h0ABC_1234);
		cmd(1, 1, 8'h03, 3'h3, 6'h03, 64'h0000_0055, 0, 1);
		res(0, 32'h0003_0003, 32'h0000_0055);
	endtask
	// Protected area and freeze lock abort
	task automatic s_lock;
		cmd(2, 0, 8'h03, 3'h3, 6'h03, 64'h0000_0099, 0, 1);
		res(32'h0000_0004, 32'h0003_0003, 32'h0000_0055);
		cmd(4, 0, 8'h03, 3'h3, 6'h03, 64'h0000_0099, 0, 0);
		res(32'h0000_0004, 32'h0003_0003, 32'h0000_0055);
	endtask

	// ************************************************************
	// Sequence, watchdog and verdict
	// ************************************************************
	task automatic summarize;
		if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		s_reset();
		s_reduce();
		s_modes();
		s_sum();
		s_drive();
		s_lock();
		summarize();
	end
	// About 15 overlays of some 1550 cycles each fit well inside this
	initial begin
		#600000;
		errors++;
		summarize();
	end
endmodule

`default_nettype wire
